// ### inc/utr_pkg.sv
// Package of constants and carrier types for the receive-side cell interface.
package utr_pkg;
  // ==========================================================================
  // Link widths and cell shape
  // ==========================================================================
  localparam int DATA_W = 8;
  localparam int ADDR_W = 5;
  localparam int CELL_OCTETS = 53;
  localparam int CNT_W = 6;
  localparam logic [CNT_W-1:0] CNT_LAST = 6'h34;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 5'h00;
  localparam logic [ADDR_W-1:0] ADDR_NULL = 5'h1F;

  // ==========================================================================
  // Carriers
  // ==========================================================================
  typedef struct packed {
    logic [DATA_W-1:0] octet;
    logic sop;
    logic eop;
    logic [ADDR_W-1:0] phy;
  } utr_octet_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_POLL,
    ST_CHECK,
    ST_SELECT,
    ST_DESELECT,
    ST_RECV
  } utr_state_t;
endpackage

// ### hw/utr_rx.sv
// Receive-side cell interface logic for the ATM-layer end of the link.
`timescale 1ns/1ns
module utr_rx #(
  parameter int NUM_PHY = 4
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic rx_interface_clock,
  input wire logic multi_phy_mode,
  input wire logic rx_cell_available_in,
  input wire logic rx_start_of_cell_in,
  input wire logic [7:0] rx_octet_bus,
  output logic [4:0] rx_phy_select_bus,
  output logic rx_accept_enable_low,
  output utr_pkg::utr_octet_t cell_octet,
  output logic cell_octet_valid,
  output logic cell_dropped
);

  // ==========================================================================
  // Link domain: reset and mode crossing into the receive clock
  // ==========================================================================
  // Reset and mode are levels from the system clock domain, so each passes two
  // flops before the link logic reads it.
  logic rst_s1_q, rst_s2_q, mode_s1_q, mode_s2_q;
  always_ff @(posedge rx_interface_clock)
  begin
    rst_s1_q <= rst_n;
    rst_s2_q <= rst_s1_q;
    mode_s1_q <= multi_phy_mode;
    mode_s2_q <= mode_s1_q;
  end
  logic lrst_n;
  assign lrst_n = rst_s2_q;

  // ==========================================================================
  // Link domain: polling, selection and cell reception
  // ==========================================================================
  utr_pkg::utr_state_t st_q, st_d;
  logic [4:0] addr_q, addr_d, poll_q, poll_d, sel_q, sel_d;
  logic enb_n_q, enb_n_d;
  logic enb_seen_n_q, enb_seen_n_d;
  logic [utr_pkg::CNT_W-1:0] cnt_q, cnt_d;
  logic [7:0] dat_q, dat_d;
  logic sop_q, sop_d, eop_q, eop_d, vld_q, vld_d, drop_q, drop_d;

  always_comb
  begin
    st_d = st_q;
    addr_d = addr_q;
    poll_d = poll_q;
    sel_d = sel_q;
    enb_n_d = 1'b1;
    enb_seen_n_d = enb_n_q;
    cnt_d = cnt_q;
    dat_d = rx_octet_bus;
    sop_d = 1'b0;
    eop_d = 1'b0;
    vld_d = 1'b0;
    drop_d = 1'b0;
    case (st_q)
      utr_pkg::ST_IDLE:
      begin
        cnt_d = '0;
        if (mode_s2_q)
        begin
          addr_d = poll_q;
          st_d = utr_pkg::ST_POLL;
        end
        else if (rx_cell_available_in)
        begin
          enb_n_d = 1'b0;
          st_d = utr_pkg::ST_RECV;
        end
      end
      utr_pkg::ST_POLL:
        st_d = utr_pkg::ST_CHECK;
      utr_pkg::ST_CHECK:
      begin
        // Cell-available answers the address presented one clock earlier.
        if (rx_cell_available_in)
        begin
          sel_d = poll_q;
          st_d = utr_pkg::ST_SELECT;
        end
        else
        begin
          poll_d = (poll_q == 5'(NUM_PHY - 1)) ? utr_pkg::ADDR_RESET : 5'(poll_q + 5'h01);
          addr_d = poll_d;
          st_d = utr_pkg::ST_POLL;
        end
      end
      utr_pkg::ST_SELECT:
      begin
        // Enable stays high in the cycle the address is presented.
        addr_d = sel_q;
        st_d = utr_pkg::ST_DESELECT;
      end
      utr_pkg::ST_DESELECT:
      begin
        enb_n_d = 1'b0;
        addr_d = utr_pkg::ADDR_NULL;
        st_d = utr_pkg::ST_RECV;
      end
      utr_pkg::ST_RECV:
      begin
        enb_n_d = 1'b0;
        if (!mode_s2_q && !rx_cell_available_in)
        begin
          enb_n_d = 1'b1;
          st_d = utr_pkg::ST_IDLE;
        end
        // The PHY answers an enable one link cycle after it samples it, so an
        // octet is taken only when the enable the PHY last saw was low.
        if (!enb_seen_n_q && rx_start_of_cell_in)
        begin
          drop_d = (cnt_q != '0);
          sop_d = 1'b1;
          vld_d = 1'b1;
          cnt_d = 6'h01;
        end
        else if (!enb_seen_n_q && cnt_q != '0)
        begin
          vld_d = 1'b1;
          if (cnt_q == utr_pkg::CNT_LAST)
          begin
            eop_d = 1'b1;
            cnt_d = '0;
            if (mode_s2_q)
            begin
              enb_n_d = 1'b1;
              poll_d = (sel_q == 5'(NUM_PHY - 1)) ? utr_pkg::ADDR_RESET : 5'(sel_q + 5'h01);
              addr_d = poll_d;
              st_d = utr_pkg::ST_POLL;
            end
          end
          else
          begin
            cnt_d = cnt_q + 6'h01;
          end
        end
        // A selected PHY goes on sending while it sees enable low, so in
        // multi-PHY mode enable rises one octet before the cell ends.
        if (mode_s2_q && cnt_d == utr_pkg::CNT_LAST)
        begin
          enb_n_d = 1'b1;
          addr_d = (sel_q == 5'(NUM_PHY - 1)) ? utr_pkg::ADDR_RESET : 5'(sel_q + 5'h01);
        end
      end
      default:
        st_d = utr_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge rx_interface_clock)
  begin
    if (!lrst_n)
    begin
      st_q <= utr_pkg::ST_IDLE;
      addr_q <= utr_pkg::ADDR_RESET;
      poll_q <= utr_pkg::ADDR_RESET;
      sel_q <= utr_pkg::ADDR_RESET;
      enb_n_q <= 1'b1;
      enb_seen_n_q <= 1'b1;
      cnt_q <= '0;
      dat_q <= 8'h00;
      sop_q <= 1'b0;
      eop_q <= 1'b0;
      vld_q <= 1'b0;
      drop_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      addr_q <= addr_d;
      poll_q <= poll_d;
      sel_q <= sel_d;
      enb_n_q <= enb_n_d;
      enb_seen_n_q <= enb_seen_n_d;
      cnt_q <= cnt_d;
      dat_q <= dat_d;
      sop_q <= sop_d;
      eop_q <= eop_d;
      vld_q <= vld_d;
      drop_q <= drop_d;
    end
  end

  // Pins leave straight from link-domain flops.
  assign rx_phy_select_bus = addr_q;
  assign rx_accept_enable_low = enb_n_q;

  // ==========================================================================
  // Crossing of octets into the system clock by a gray-coded slot pointer
  // ==========================================================================
  // Octets come back to back, one per link cycle, so a single held word would
  // be overwritten before its flag had crossed. Eight slots behind a gray write
  // pointer keep each octet still far longer than the crossing takes; the system
  // side reads one slot per cycle and keeps up only while its clock is faster.
  utr_pkg::utr_octet_t slot_q [8];
  utr_pkg::utr_octet_t slot_d [8];
  logic [2:0] wbin_q, wbin_d, wgray_q, wgray_d;
  logic drop_tgl_q, drop_tgl_d;
  always_comb
  begin
    slot_d = slot_q;
    wbin_d = wbin_q + {2'b00, vld_q};
    wgray_d = wbin_d ^ (wbin_d >> 1);
    drop_tgl_d = drop_tgl_q ^ drop_q;
    if (vld_q)
    begin
      slot_d[wbin_q] = '{octet: dat_q, sop: sop_q, eop: eop_q, phy: sel_q};
    end
  end
  always_ff @(posedge rx_interface_clock)
  begin
    if (!lrst_n)
    begin
      slot_q <= '{default: '0};
      wbin_q <= 3'h0;
      wgray_q <= 3'h0;
      drop_tgl_q <= 1'b0;
    end
    else
    begin
      slot_q <= slot_d;
      wbin_q <= wbin_d;
      wgray_q <= wgray_d;
      drop_tgl_q <= drop_tgl_d;
    end
  end

  logic [2:0] w1_q, w2_q, rbin_q, rbin_d, rgray;
  logic d1_q, d2_q, d3_q;
  utr_pkg::utr_octet_t out_q, out_d;
  logic ov_q, ov_d, dr_q, dr_d;
  always_comb
  begin
    rgray = rbin_q ^ (rbin_q >> 1);
    ov_d = (rgray != w2_q);
    rbin_d = rbin_q + {2'b00, ov_d};
    dr_d = d2_q ^ d3_q;
    out_d = ov_d ? slot_q[rbin_q] : out_q;
  end
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      w1_q <= 3'h0;
      w2_q <= 3'h0;
      rbin_q <= 3'h0;
      d1_q <= 1'b0;
      d2_q <= 1'b0;
      d3_q <= 1'b0;
      out_q <= '0;
      ov_q <= 1'b0;
      dr_q <= 1'b0;
    end
    else
    begin
      w1_q <= wgray_q;
      w2_q <= w1_q;
      rbin_q <= rbin_d;
      d1_q <= drop_tgl_q;
      d2_q <= d1_q;
      d3_q <= d2_q;
      out_q <= out_d;
      ov_q <= ov_d;
      dr_q <= dr_d;
    end
  end
  assign cell_octet = out_q;
  assign cell_octet_valid = ov_q;
  assign cell_dropped = dr_q;
endmodule

// ### tb/utr_rx_checker.sv
// Assertions on the ports of the receive cell interface.
`timescale 1ns/1ns
module utr_rx_checker #(
  parameter int NUM_PHY = 4
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic rx_interface_clock,
  input wire logic multi_phy_mode,
  input wire logic rx_cell_available_in,
  input wire logic [4:0] rx_phy_select_bus,
  input wire logic rx_accept_enable_low,
  input wire utr_pkg::utr_octet_t cell_octet,
  input wire logic cell_octet_valid,
  input wire logic cell_dropped
);
  // Link logic leaves reset some link edges after rst_n, so link checks wait for it.
  logic [4:0] lk_q;
  logic [4:0] lk_d;
  always_comb lk_d = rst_n ? {lk_q[3:0], 1'b1} : 5'h00;
  always_ff @(posedge rx_interface_clock) lk_q <= lk_d;
  a_poll_range: assert property (@(posedge rx_interface_clock) disable iff (!lk_q[4])
    multi_phy_mode && rx_accept_enable_low |-> rx_phy_select_bus < NUM_PHY) else $error("poll address");
  a_select_null: assert property (@(posedge rx_interface_clock) disable iff (!lk_q[4])
    multi_phy_mode && $fell(rx_accept_enable_low) |-> rx_phy_select_bus == utr_pkg::ADDR_NULL) else $error("select");
  a_hold_low: assert property (@(posedge rx_interface_clock) disable iff (!lk_q[4])
    multi_phy_mode && $fell(rx_accept_enable_low) |=> !rx_accept_enable_low [*8]) else $error("enable hold");
  a_single_accept: assert property (@(posedge rx_interface_clock) disable iff (!lk_q[4])
    !multi_phy_mode |=> rx_accept_enable_low == !$past(rx_cell_available_in)) else $error("single enable");
  a_octet_hold: assert property (@(posedge clock) disable iff (!rst_n)
    !cell_octet_valid |-> $stable(cell_octet)) else $error("octet hold");
  a_drop_pulse: assert property (@(posedge clock) disable iff (!rst_n)
    cell_dropped |=> !cell_dropped) else $error("drop pulse");
endmodule
bind utr_rx utr_rx_checker #(.NUM_PHY(NUM_PHY)) utr_rx_checker_i (.clock, .rst_n, .rx_interface_clock,
  .multi_phy_mode, .rx_cell_available_in, .rx_phy_select_bus, .rx_accept_enable_low, .cell_octet,
  .cell_octet_valid, .cell_dropped);

// ### tb/utr_phy_model.sv
// Behavioural cell source standing in for one PHY on the link.
`timescale 1ns/1ns
module utr_phy_model #(
  parameter logic [4:0] MY_ADDR = 5'h02
) (
  input wire logic rx_interface_clock,
  input wire logic rst_n,
  input wire logic multi_phy_mode,
  input wire logic [4:0] rx_phy_select_bus,
  input wire logic rx_accept_enable_low,
  input wire integer cells,
  input wire integer cut,
  output logic rx_cell_available_in,
  output logic rx_start_of_cell_in,
  output logic [7:0] rx_octet_bus
);
  int left;
  int cnt;
  logic sel;
  logic en_q;
  logic [4:0] adr_q;
  always @(posedge rx_interface_clock)
  begin
    if (!rst_n)
    begin
      left = cells;
      cnt = 0;
      sel = 0;
      rx_octet_bus <= 8'hFF;
      rx_start_of_cell_in <= 1'b0;
    end
    else
    begin
      // Selection takes effect on the edge that first sees enable low.
      if (en_q && !rx_accept_enable_low)
        sel = adr_q == MY_ADDR;
      // Data only follows an enable that was low, and in multi-PHY mode only from the selected PHY.
      if ((!multi_phy_mode || sel) && !rx_accept_enable_low && left > 0)
      begin
        rx_octet_bus <= 8'hA0 + cnt[7:0];
        rx_start_of_cell_in <= cnt == 0;
        cnt = cnt + 1;
        if (cnt == (left == cells ? cut : 53))
        begin
          cnt = 0;
          left = left - 1;
        end
      end
      else
      begin
        // Released lines fall to their pull-ups; a driven idle bus keeps changing.
        rx_octet_bus <= (!multi_phy_mode || sel) ? ~rx_octet_bus : 8'hFF;
        rx_start_of_cell_in <= multi_phy_mode && !sel;
      end
    end
    en_q <= rx_accept_enable_low;
    adr_q <= rx_phy_select_bus;
    rx_cell_available_in <= rst_n && left > 0 && (!multi_phy_mode || rx_phy_select_bus == MY_ADDR);
  end
endmodule

// ### tb/testbench.sv
// Self-checking bench for the receive cell interface.
`timescale 1ns/1ns
module testbench;
  logic clock = 1'b0;
  logic rx_interface_clock = 1'b0;
  logic rst_n = 1'b0;
  logic multi_phy_mode = 1'b1;
  logic rx_cell_available_in, rx_start_of_cell_in, rx_accept_enable_low, cell_octet_valid, cell_dropped;
  logic [7:0] rx_octet_bus;
  logic [4:0] rx_phy_select_bus;
  utr_pkg::utr_octet_t cell_octet;
  int cells = 0;
  int cut = 53;
  int n_mismatch = 0;
  int checks = 0;
  int nv, ns, ne, nd, idx;
  initial forever #20 clock = ~clock;
  initial
  begin
    #7;
    forever #24 rx_interface_clock = ~rx_interface_clock;
  end
  utr_rx utr_rx_i (.clock, .rst_n, .rx_interface_clock, .multi_phy_mode, .rx_cell_available_in,
    .rx_start_of_cell_in, .rx_octet_bus, .rx_phy_select_bus, .rx_accept_enable_low, .cell_octet,
    .cell_octet_valid, .cell_dropped);
  utr_phy_model utr_phy_model_i (.rx_interface_clock, .rst_n, .multi_phy_mode, .rx_phy_select_bus,
    .rx_accept_enable_low, .cells, .cut, .rx_cell_available_in, .rx_start_of_cell_in, .rx_octet_bus);
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("FAIL %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  always @(negedge clock)
  begin
    if (rst_n && cell_dropped)
      nd++;
    if (rst_n && cell_octet_valid)
    begin
      if (cell_octet.sop)
        idx = 0;
      check("octet", cell_octet.octet, 8'hA0 + idx[7:0]);
      check("end flag", cell_octet.eop, idx == 52);
      if (multi_phy_mode)
        check("phy", cell_octet.phy, 5'h02);
      nv++;
      ns += cell_octet.sop;
      ne += cell_octet.eop;
      idx++;
    end
  end
  // Reset is held past the link side's own reset span before each run.
  task automatic run(input logic m, input int c, input int k, input int ev);
    @(negedge clock);
    rst_n = 1'b0;
    multi_phy_mode = m;
    cells = c;
    cut = k;
    {nv, ns, ne, nd, idx} = '0;
    repeat (8) @(negedge clock);
    rst_n = 1'b1;
    for (int i = 0; i < 6000 && nv < ev; i++)
      @(negedge clock);
    repeat (200) @(negedge clock);
  endtask
  task automatic multi_two_cells();
    run(1'b1, 2, 53, 106);
    check("octets", nv, 106);
    check("starts", ns, 2);
    check("ends", ne, 2);
    check("drops", nd, 0);
  endtask
  task automatic multi_early_start();
    run(1'b1, 2, 20, 73);
    check("octets", nv, 73);
    check("ends", ne, 1);
    check("drops", nd, 1);
  endtask
  task automatic single_cell();
    run(1'b0, 1, 53, 53);
    check("octets", nv, 53);
    check("ends", ne, 1);
    check("enable", rx_accept_enable_low, 1'b1);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    repeat (40000) @(posedge clock);
    n_mismatch++;
    final_report();
  end
  initial
  begin
    multi_two_cells();
    multi_early_start();
    single_cell();
    final_report();
  end
endmodule
